// ==== hdl/cmg_pkg.sv ====
// Constants shared by the colour memory game
package cmg_pkg;
  // Clock rate of mclk_in
  localparam int CLK_HZ = 20000000;
  // Time of one lit colour while the sequence is shown, in ms
  localparam int STEP_MS = 400;
  // Dark gap between two shown colours, in ms
  localparam int GAP_MS = 150;
  // Length of one melody note, in ms
  localparam int NOTE_MS = 120;
  // Time each score digit stays lit, in us
  localparam int MUX_US = 1000;
  // Tone time base, in us
  localparam int TICK_US = 10;
  // Derived cycle counts
  localparam int STEP_CYC = CLK_HZ / 1000 * STEP_MS;
  localparam int GAP_CYC = CLK_HZ / 1000 * GAP_MS;
  localparam int NOTE_CYC = CLK_HZ / 1000 * NOTE_MS;
  localparam int MUX_CYC = CLK_HZ / 1000000 * MUX_US;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  // Timer and sequence sizes
  localparam int TIMER_W = 24;
  localparam int MAX_LEN = 32;
  localparam logic [6:0] SCORE_MAX = 7'h63;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  // Tone half periods in ticks per colour, colour 0 in the low byte
  localparam logic [31:0] TONE_HALF = {8'h5f, 8'h7f, 8'h97, 8'hbf};
  // Game states
  typedef enum logic [2:0] {
    CMG_IDLE = 3'b000,
    CMG_ADD = 3'b001,
    CMG_SHOW_ON = 3'b010,
    CMG_SHOW_GAP = 3'b011,
    CMG_WAIT_PRESS = 3'b100,
    CMG_PRESS_HOLD = 3'b101,
    CMG_LEVEL_UP = 3'b110,
    CMG_GAME_OVER = 3'b111
  } cmg_state_t;
endpackage : cmg_pkg

// ==== hdl/cmg_seg_mux.sv ====
// Two digit multiplexed seven segment score driver
`timescale 1ns/1ps
module cmg_seg_mux #(
  parameter int MUX_CYC = cmg_pkg::MUX_CYC
) (
  input wire logic mclk_in, // System clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic [6:0] score_in, // Binary score 0 to 99
  input wire logic seg_invert_in, // High for common anode
  output logic [6:0] seg_out, // Segments a to g, a in bit 0
  output logic tens_digit_select_out, // Common pin of tens digit
  output logic ones_digit_select_out // Common pin of ones digit
);
  logic [23:0] mux_cnt;
  logic show_ones;
  logic [3:0] tens_val;
  logic [3:0] ones_val;
  logic [3:0] cur_val;
  logic [6:0] pattern;
  logic [6:0] next_seg;
  logic digit_on;

  // Split the score into decimal digits and pick one
  assign tens_val = 4'(score_in / 7'd10);
  assign ones_val = 4'(score_in % 7'd10);
  assign cur_val = show_ones ? ones_val : tens_val;
  // [R9] Polarity select
  assign next_seg = seg_invert_in ? ~pattern : pattern;
  assign digit_on = seg_invert_in;

  // Segment pattern of one decimal digit, active high
  always_comb begin
    case (cur_val)
      4'h0: pattern = 7'h3f;
      4'h1: pattern = 7'h06;
      4'h2: pattern = 7'h5b;
      4'h3: pattern = 7'h4f;
      4'h4: pattern = 7'h66;
      4'h5: pattern = 7'h6d;
      4'h6: pattern = 7'h7d;
      4'h7: pattern = 7'h07;
      4'h8: pattern = 7'h7f;
      4'h9: pattern = 7'h6f;
      default: pattern = 7'h00;
    endcase
  end

  // [R13] Digit alternation timer
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      mux_cnt <= 24'h000000;
      show_ones <= 1'b0;
    end else if (mux_cnt == 24'(MUX_CYC - 1)) begin
      mux_cnt <= 24'h000000;
      show_ones <= ~show_ones;
    end else begin
      mux_cnt <= mux_cnt + 24'h000001;
    end
  end

  // [R10] Tens on the first select, ones on the second
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      seg_out <= 7'h00;
      tens_digit_select_out <= 1'b0;
      ones_digit_select_out <= 1'b0;
    end else begin
      seg_out <= next_seg;
      tens_digit_select_out <= show_ones ? ~digit_on : digit_on;
      ones_digit_select_out <= show_ones ? digit_on : ~digit_on;
    end
  end

  a_one_digit_on: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R13]
    $past(reset_n_in) |-> (tens_digit_select_out != ones_digit_select_out))
    else $error("both digit selects in the same state");
  a_seg_polarity: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R9]
    $past(reset_n_in) && $past(seg_invert_in) |-> seg_out == ~$past(pattern))
    else $error("segments not inverted for common anode");
  a_tens_digit: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R10]
    $past(reset_n_in) && $past(!show_ones) |-> tens_digit_select_out == $past(seg_invert_in))
    else $error("tens digit not selected in its slot");
endmodule : cmg_seg_mux

// ==== hdl/cmg_top.sv ====
// Colour memory game: sequence, tones, buttons and score
`timescale 1ns/1ps
// How it works
// [R1] After reset stay idle until any button is pressed, then start.
// [R2] Each turn light the LED of every sequence colour in order.
// [R3] While a colour shows, speaker plays that colour's own fixed tone.
// [R4] After showing, take presses and compare each with the expected colour.
// [R5] Full match: level-up melody, append a colour, next turn.
// [R6] Wrong press: game-over melody, then restart from the initial state.
// [R7] Button n stands for the colour on LED n.
// [R8] A button reads as pressed when its input is high.
// [R9] Polarity input high drives common anode, low common cathode.
// [R10] Tens digit on first digit select, ones on the second.
// [R11] The system supplies the clock that all pitches and timings count.
// [R12] Each new colour comes from a free-running LFSR sampled then.
// [R13] Score digits alternate with only one select active at a time; reset drives both selects low, so both are active for common cathode.
module cmg_top #(
  parameter int STEP_CYC = cmg_pkg::STEP_CYC,
  parameter int GAP_CYC = cmg_pkg::GAP_CYC,
  parameter int NOTE_CYC = cmg_pkg::NOTE_CYC,
  parameter int MUX_CYC = cmg_pkg::MUX_CYC
) (
  input wire logic mclk_in, // System clock
  input wire logic reset_n_in, // Synchronous reset, active low
  input wire logic button_one_in, // Colour 0 button, high when pressed
  input wire logic button_two_in, // Colour 1 button
  input wire logic button_three_in, // Colour 2 button
  input wire logic button_four_in, // Colour 3 button
  input wire logic seg_invert_in, // High for common anode display
  output logic lamp_one_out, // Colour 0 LED
  output logic lamp_two_out, // Colour 1 LED
  output logic lamp_three_out, // Colour 2 LED
  output logic lamp_four_out, // Colour 3 LED
  output logic speaker_out, // Tone square wave
  output logic [6:0] seg_out, // Segments a to g
  output logic tens_digit_select_out, // Tens digit common pin
  output logic ones_digit_select_out // Ones digit common pin
);
  cmg_pkg::cmg_state_t state;
  logic [1:0] seq_mem [cmg_pkg::MAX_LEN];
  logic [5:0] seq_len;
  logic [4:0] pos;
  logic [1:0] press_col;
  logic [1:0] note;
  logic [6:0] score;
  logic [cmg_pkg::TIMER_W-1:0] timer;
  logic [7:0] lfsr;
  logic [7:0] tick_cnt;
  logic [7:0] tone_cnt;
  logic [3:0] buttons;
  logic any_btn;
  logic [1:0] first_btn;
  logic [1:0] expect_col;
  logic match;
  logic last_pos;
  logic timer_done;
  logic tick;
  logic light_en;
  logic [1:0] light_col;
  logic [3:0] next_lamps;
  logic [7:0] half_period;

  // [R8] Active-high buttons, [R7] button n maps to colour n
  assign buttons = {button_four_in, button_three_in, button_two_in, button_one_in};
  assign any_btn = |buttons;
  assign first_btn = buttons[0] ? 2'd0 : buttons[1] ? 2'd1 : buttons[2] ? 2'd2 : 2'd3;
  // [R4] Compare the press with the expected colour
  assign expect_col = seq_mem[pos];
  assign match = (press_col == expect_col);
  assign last_pos = ({1'b0, pos} == seq_len - 6'd1);
  assign timer_done = (timer == '0);
  assign tick = (tick_cnt == 8'(cmg_pkg::TICK_CYC - 1));

  // Which colour is lit and sounding in each state
  assign light_en = (state == cmg_pkg::CMG_SHOW_ON) || (state == cmg_pkg::CMG_PRESS_HOLD) ||
                    (state == cmg_pkg::CMG_LEVEL_UP) || (state == cmg_pkg::CMG_GAME_OVER);
  assign light_col = (state == cmg_pkg::CMG_SHOW_ON) ? expect_col :
                     (state == cmg_pkg::CMG_PRESS_HOLD) ? press_col :
                     (state == cmg_pkg::CMG_LEVEL_UP) ? note : ~note;
  assign next_lamps = light_en ? (4'h1 << light_col) : 4'h0;
  // [R3] Fixed pitch per colour
  assign half_period = cmg_pkg::TONE_HALF[light_col*8 +: 8];

  // [R12] Free-running LFSR
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      lfsr <= cmg_pkg::LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // Game sequencer
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state <= cmg_pkg::CMG_IDLE;
      seq_len <= 6'h00;
      pos <= 5'h00;
      press_col <= 2'h0;
      note <= 2'h0;
      score <= 7'h00;
      timer <= '0;
    end else begin
      if (!timer_done) begin
        timer <= timer - cmg_pkg::TIMER_W'(1);
      end
      case (state)
        // [R1] Idle until a press
        cmg_pkg::CMG_IDLE: begin
          if (any_btn) begin
            state <= cmg_pkg::CMG_ADD;
          end
        end
        // [R5] Append a colour once buttons are released
        cmg_pkg::CMG_ADD: begin
          if (!any_btn) begin
            if (seq_len != 6'(cmg_pkg::MAX_LEN)) begin
              seq_len <= seq_len + 6'h01;
            end
            pos <= 5'h00;
            timer <= cmg_pkg::TIMER_W'(GAP_CYC);
            state <= cmg_pkg::CMG_SHOW_GAP;
          end
        end
        cmg_pkg::CMG_SHOW_GAP: begin
          if (timer_done) begin
            timer <= cmg_pkg::TIMER_W'(STEP_CYC);
            state <= cmg_pkg::CMG_SHOW_ON;
          end
        end
        // [R2] Show each colour in order
        cmg_pkg::CMG_SHOW_ON: begin
          if (timer_done) begin
            if (last_pos) begin
              pos <= 5'h00;
              state <= cmg_pkg::CMG_WAIT_PRESS;
            end else begin
              pos <= pos + 5'h01;
              timer <= cmg_pkg::TIMER_W'(GAP_CYC);
              state <= cmg_pkg::CMG_SHOW_GAP;
            end
          end
        end
        // [R7] Capture the pressed colour
        cmg_pkg::CMG_WAIT_PRESS: begin
          if (any_btn) begin
            press_col <= first_btn;
            state <= cmg_pkg::CMG_PRESS_HOLD;
          end
        end
        // [R4] Judge the press on release
        cmg_pkg::CMG_PRESS_HOLD: begin
          if (!any_btn) begin
            note <= 2'h0;
            timer <= cmg_pkg::TIMER_W'(NOTE_CYC);
            if (!match) begin
              state <= cmg_pkg::CMG_GAME_OVER;
            end else if (last_pos) begin
              if (score != cmg_pkg::SCORE_MAX) begin
                score <= score + 7'h01;
              end
              state <= cmg_pkg::CMG_LEVEL_UP;
            end else begin
              pos <= pos + 5'h01;
              state <= cmg_pkg::CMG_WAIT_PRESS;
            end
          end
        end
        // [R5] Rising four-note melody, then next turn
        cmg_pkg::CMG_LEVEL_UP: begin
          if (timer_done) begin
            note <= note + 2'h1;
            timer <= cmg_pkg::TIMER_W'(NOTE_CYC);
            if (note == 2'h3) begin
              state <= cmg_pkg::CMG_ADD;
            end
          end
        end
        // [R6] Falling melody, then back to the initial state
        cmg_pkg::CMG_GAME_OVER: begin
          if (timer_done) begin
            note <= note + 2'h1;
            timer <= cmg_pkg::TIMER_W'(NOTE_CYC);
            if (note == 2'h3) begin
              seq_len <= 6'h00;
              pos <= 5'h00;
              score <= 7'h00;
              state <= cmg_pkg::CMG_IDLE;
            end
          end
        end
        default: state <= cmg_pkg::CMG_IDLE;
      endcase
    end
  end

  // [R12] Store the sampled colour at the new end
  always_ff @(posedge mclk_in) begin
    if (state == cmg_pkg::CMG_ADD && !any_btn && seq_len != 6'(cmg_pkg::MAX_LEN)) begin
      seq_mem[seq_len[4:0]] <= lfsr[1:0];
    end
  end

  // [R3] Tone generator and lamp drivers
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      tick_cnt <= 8'h00;
      tone_cnt <= 8'h00;
      speaker_out <= 1'b0;
      {lamp_four_out, lamp_three_out, lamp_two_out, lamp_one_out} <= 4'h0;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      {lamp_four_out, lamp_three_out, lamp_two_out, lamp_one_out} <= next_lamps;
      if (!light_en) begin
        tone_cnt <= 8'h00;
        speaker_out <= 1'b0;
      end else if (tick) begin
        if (tone_cnt == 8'h00) begin
          tone_cnt <= half_period - 8'h01;
          speaker_out <= ~speaker_out;
        end else begin
          tone_cnt <= tone_cnt - 8'h01;
        end
      end
    end
  end

  // [R9] [R10] [R13] Score display
  cmg_seg_mux #(.MUX_CYC(MUX_CYC)) u_seg (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .score_in(score),
    .seg_invert_in(seg_invert_in),
    .seg_out(seg_out),
    .tens_digit_select_out(tens_digit_select_out),
    .ones_digit_select_out(ones_digit_select_out)
  );

  sequence s_melody_end;
    timer_done && note == 2'h3;
  endsequence
  sequence s_appended;
    state == cmg_pkg::CMG_ADD ##1 state == cmg_pkg::CMG_SHOW_GAP;
  endsequence

  a_idle_wait: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R1]
    state == cmg_pkg::CMG_IDLE && !any_btn |=> state == cmg_pkg::CMG_IDLE)
    else $error("left idle without a press");
  a_show_lamp: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R2]
    state == cmg_pkg::CMG_SHOW_ON && $past(state) == cmg_pkg::CMG_SHOW_ON
    |-> {lamp_four_out, lamp_three_out, lamp_two_out, lamp_one_out} == (4'h1 << expect_col))
    else $error("shown lamp differs from sequence colour");
  a_tone_edge: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R3]
    $past(light_en) && light_en && $changed(speaker_out) |-> $past(tick && tone_cnt == 8'h00))
    else $error("speaker toggled off its half period");
  a_press_map: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R7]
    state == cmg_pkg::CMG_WAIT_PRESS && any_btn
    |=> state == cmg_pkg::CMG_PRESS_HOLD && press_col == $past(first_btn))
    else $error("pressed button not captured as its colour");
  a_wrong_press: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R6]
    state == cmg_pkg::CMG_PRESS_HOLD && !any_btn && !match |=> state == cmg_pkg::CMG_GAME_OVER)
    else $error("wrong press did not end the game");
  a_over_restart: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R6]
    (state == cmg_pkg::CMG_GAME_OVER and s_melody_end) |=> state == cmg_pkg::CMG_IDLE && seq_len == 6'h00)
    else $error("game over did not restart");
  a_level_grow: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R5]
    (state == cmg_pkg::CMG_LEVEL_UP and s_melody_end) ##1 s_appended
    |-> seq_len == $past(seq_len) + 6'h01 || seq_len == 6'(cmg_pkg::MAX_LEN))
    else $error("sequence not extended after level up");
  a_new_colour: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [R12]
    s_appended ##0 ($past(seq_len) != 6'(cmg_pkg::MAX_LEN))
    |-> seq_mem[5'($past(seq_len))] == $past(lfsr[1:0]))
    else $error("appended colour not taken from the LFSR");
endmodule : cmg_top

// ==== verif/cmg_panel.sv ====
// Outside-world panel model: lamps, score display and a recorder of shown colours
`timescale 1ns/1ps
module cmg_panel (
  input wire logic mclk_in, // System clock
  input wire logic reset_n_in, // Reset seen by the game
  input wire logic clr_in, // High stops recording and forgets the count
  input wire logic [3:0] lamps_in, // Lamps, colour 0 in bit 0
  input wire logic [6:0] seg_in, // Raw segment pins
  input wire logic tens_digit_select_in, // Raw tens common pin
  input wire logic ones_digit_select_in, // Raw ones common pin
  input wire logic seg_invert_in, // Display polarity strap
  output logic [6:0] ones_seg_out, // Last ones pattern, active high
  output int shown_out, // Colours seen since recording restarted
  output int faults_out // Cycles with overlapping lamps, or with both digit selects on or both off
);
  logic [1:0] seq [0:31];
  logic [3:0] prev_lamps;
  logic rst_q;
  wire [6:0] seg_lit = seg_invert_in ? ~seg_in : seg_in;
  wire tens_on = tens_digit_select_in === seg_invert_in;
  wire ones_on = ones_digit_select_in === seg_invert_in;
  initial begin
    shown_out = 0;
    faults_out = 0;
    prev_lamps = 4'h0;
    rst_q = 1'b0;
    ones_seg_out = 7'h00;
  end
  // Record each newly lit lamp and watch the display
  always @(posedge mclk_in) begin
    rst_q <= reset_n_in;
    prev_lamps <= lamps_in;
    if (clr_in) begin
      shown_out <= 0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (lamps_in[k] === 1'b1 && prev_lamps[k] !== 1'b1 && shown_out < 32) begin
          seq[shown_out] <= 2'(k);
          shown_out <= shown_out + 1;
        end
      end
    end
    if (reset_n_in && rst_q && (tens_on == ones_on || $countones(lamps_in) > 1)) faults_out <= faults_out + 1;
    if (ones_on) ones_seg_out <= seg_lit;
  end
endmodule : cmg_panel

// ==== verif/test_color_memory_game.sv ====
// Self-checking bench for the colour memory game
`timescale 1ns/1ps
module test_color_memory_game;
  logic mclk_in;
  logic reset_n_in;
  logic seg_invert_in;
  logic clr;
  logic [3:0] btn;
  wire [3:0] lamps;
  wire speaker;
  wire [6:0] seg;
  wire tens_sel;
  wire ones_sel;
  wire [6:0] ones_seg;
  int shown;
  int faults;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Short timings so a whole game fits the run
  cmg_top #(.STEP_CYC(40), .GAP_CYC(20), .NOTE_CYC(30), .MUX_CYC(8)) dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .button_one_in(btn[0]), .button_two_in(btn[1]),
    .button_three_in(btn[2]), .button_four_in(btn[3]), .seg_invert_in(seg_invert_in),
    .lamp_one_out(lamps[0]), .lamp_two_out(lamps[1]), .lamp_three_out(lamps[2]), .lamp_four_out(lamps[3]),
    .speaker_out(speaker), .seg_out(seg), .tens_digit_select_out(tens_sel), .ones_digit_select_out(ones_sel));
  cmg_panel panel_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .clr_in(clr), .lamps_in(lamps), .seg_in(seg),
    .tens_digit_select_in(tens_sel), .ones_digit_select_in(ones_sel), .seg_invert_in(seg_invert_in),
    .ones_seg_out(ones_seg), .shown_out(shown), .faults_out(faults));
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  // Hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 99000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_vec(input string what, input logic [6:0] exp, input logic [6:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec
  task automatic chk_num(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_num
  task automatic step(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : step
  // Record the sequence as it is shown
  task automatic wait_shown(input int n);
    int i;
    i = 0;
    clr = 1'b0;
    while (!(shown >= n && lamps === 4'h0) && i < 5000) begin
      step(1);
      i++;
    end
    chk_num("shown colours", n, shown);
    clr = 1'b1;
  endtask : wait_shown
  // One correct-length press of colour c
  task automatic press(input int c);
    step(3);
    btn[c] = 1'b1;
    step(3);
    chk_vec("press lamp", 7'(4'h1 << c), 7'(lamps));
    step(4);
    btn[c] = 1'b0;
  endtask : press
  // Melody lamps, two bits of order per note
  task automatic melody(input logic [7:0] order);
    step(17);
    for (int k = 0; k < 4; k++) begin
      chk_vec("melody lamp", 7'(4'h1 << order[k*2 +: 2]), 7'(lamps));
      step(31);
    end
  endtask : melody
  // Idle after reset, display polarity both ways
  task automatic t_idle();
    step(200);
    chk_vec("idle lamps", 7'h00, 7'(lamps));
    chk_bit("idle speaker", 1'b0, speaker);
    chk_vec("ones digit zero", 7'h3f, ones_seg);
    seg_invert_in = 1'b1;
    step(40);
    chk_vec("anode ones digit", 7'h3f, ones_seg);
    seg_invert_in = 1'b0;
    step(40);
  endtask : t_idle
  // Any button starts the game with one colour
  task automatic t_start(input int c);
    btn[c] = 1'b1;
    step(3);
    btn[c] = 1'b0;
    wait_shown(1);
  endtask : t_start
  // Repeat the sequence, see the level-up melody lamps, see it grow
  task automatic t_level(input int len, input logic [6:0] ones);
    logic [1:0] old [0:31];
    old = panel_u.seq;
    for (int i = 0; i < len; i++) press(int'(old[i]));
    melody(8'b11_10_01_00);
    wait_shown(len + 1);
    for (int i = 0; i < len; i++) chk_vec("kept colour", 7'(old[i]), 7'(panel_u.seq[i]));
    chk_vec("score ones digit", ones, ones_seg);
  endtask : t_level
  // Wrong colour held: its tone, then game over and idle
  task automatic t_wrong_tone();
    int c;
    int half;
    int i;
    c = (int'(panel_u.seq[0]) + 1) % 4;
    half = int'(cmg_pkg::TONE_HALF[c*8 +: 8]) * cmg_pkg::TICK_CYC;
    step(3);
    btn[c] = 1'b1;
    i = 0;
    while (speaker !== 1'b1 && i < 2 * half + 400) begin
      step(1);
      i++;
    end
    i = 0;
    while (speaker === 1'b1 && i < 2 * half) begin
      step(1);
      i++;
    end
    chk_num("tone half period", half, i);
    btn[c] = 1'b0;
    melody(8'b00_01_10_11);
    step(300);
    chk_vec("idle after game over", 7'h00, 7'(lamps));
    chk_vec("score cleared", 7'h3f, ones_seg);
  endtask : t_wrong_tone
  initial begin
    reset_n_in = 1'b0;
    seg_invert_in = 1'b0;
    clr = 1'b1;
    btn = 4'h0;
    step(20);
    reset_n_in = 1'b1;
    t_idle();
    t_start(1);
    t_level(1, 7'h06);
    t_level(2, 7'h5b);
    t_wrong_tone();
    t_start(3);
    chk_num("overlap cycles", 0, faults);
    wrap_up();
  end
endmodule : test_color_memory_game
